// ==== rtl/prnr_pkg.sv ====
// Constants, register map and field layout of the peripheral reset and NMI routing bank.
// Assumes a 32-bit AXI4-Lite master and a single 20 MHz system clock.
package prnr_pkg;
	// ****************************************
	// Addresses
	// ****************************************
	localparam logic [31:0] UNIT_BASE = 32'h4000_3000;
	localparam logic [31:0] OFS_CORE_CE = 32'h0000_0000;
	localparam logic [31:0] OFS_CORE_RST = 32'h0000_0004;
	localparam logic [31:0] OFS_KEY = 32'h0000_000C;
	localparam logic [31:0] OFS_SYS_SEL = 32'h0000_0014;
	localparam logic [31:0] OFS_PER_SEL = 32'h0000_0018;
	localparam logic [31:0] OFS_PLL = 32'h0000_001C;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0020;
	localparam logic [31:0] OFS_CALIB = 32'h0000_0028;
	localparam logic [31:0] OFS_ROUTE = 32'h0000_002C;
	localparam logic [31:0] OFS_EVENT = 32'h0000_0030;
	localparam logic [31:0] OFS_MASK = 32'h0000_0034;
	localparam logic [31:0] ADDR_G0_CE = 32'h4002_0000;
	localparam logic [31:0] ADDR_G0_RST = 32'h4002_0004;
	localparam logic [31:0] ADDR_G1_CE = 32'h4002_1000;
	localparam logic [31:0] ADDR_G1_RST = 32'h4002_1004;
	localparam logic [31:0] ADDR_G2_CE = 32'h4002_2000;
	localparam logic [31:0] ADDR_G2_RST = 32'h4002_2004;
	// ****************************************
	// Decoded register indices
	// ****************************************
	localparam logic [4:0] IDX_CORE_CE = 5'h00;
	localparam logic [4:0] IDX_CORE_RST = 5'h01;
	localparam logic [4:0] IDX_KEY = 5'h02;
	localparam logic [4:0] IDX_SYS_SEL = 5'h03;
	localparam logic [4:0] IDX_PER_SEL = 5'h04;
	localparam logic [4:0] IDX_PLL = 5'h05;
	localparam logic [4:0] IDX_CALIB = 5'h06;
	localparam logic [4:0] IDX_STATUS = 5'h07;
	localparam logic [4:0] IDX_ROUTE = 5'h08;
	localparam logic [4:0] IDX_G0_CE = 5'h09;
	localparam logic [4:0] IDX_G0_RST = 5'h0A;
	localparam logic [4:0] IDX_G1_CE = 5'h0B;
	localparam logic [4:0] IDX_G1_RST = 5'h0C;
	localparam logic [4:0] IDX_G2_CE = 5'h0D;
	localparam logic [4:0] IDX_G2_RST = 5'h0E;
	localparam logic [4:0] IDX_EVENT = 5'h0F;
	localparam logic [4:0] IDX_MASK = 5'h10;
	localparam logic [4:0] IDX_NONE = 5'h1F;
	localparam int MISC_COUNT = 5;
	// ****************************************
	// Reset values and writable masks
	// ****************************************
	localparam logic [31:0] RST_CORE_CE = 32'h0020_0000;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] MASK_CORE_CE = 32'h0070_0007;
	localparam logic [31:0] MASK_G0_CE = 32'h00F0_01FF;
	localparam logic [31:0] MASK_G1_CE = 32'h00F0_009F;
	localparam logic [31:0] MASK_G2_CE = 32'h00F0_0007;
	localparam logic [31:0] MASK_CORE_RST = 32'h0000_0003;
	localparam logic [31:0] MASK_G0_RST = 32'h0000_01FF;
	localparam logic [31:0] MASK_G1_RST = 32'h0000_009F;
	localparam logic [31:0] MASK_G2_RST = 32'h0000_0007;
	// ****************************************
	// Fields
	// ****************************************
	localparam int CLKDIV_LSB = 20;
	localparam int KEY_LSB = 16;
	localparam logic [15:0] KEY_VALUE = 16'hA05F;
	localparam int ROUTE_LINE0_BIT = 2;
	localparam int ROUTE_CMP_BIT = 1;
	localparam int ROUTE_CLKF_BIT = 0;
	localparam int STS_CLKFAIL_BIT = 0;
	localparam int EV_CLKFAIL_BIT = 0;
	localparam int EV_NMI_BIT = 1;
	localparam int EV_KEYREJ_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : prnr_pkg

// ==== rtl/prnr_rst_pulse.sv ====
// Self-clearing peripheral reset bits for one bus group.
// Assumes set requests are one-cycle pulses already masked to the implemented bits.
`timescale 1ns/10ps
module prnr_rst_pulse #(
	parameter int WIDTH = 8
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_set,
	input wire logic [2:0] i_div_sel,
	output logic [WIDTH-1:0] o_active
);
	// ****************************************
	// Bus clock enable divider
	// ****************************************
	logic [6:0] div_cnt_q;
	logic [6:0] div_mask;
	logic tick;
	assign div_mask = 7'(({1'b0, 7'h7F} << i_div_sel) >> 7) | 7'((8'h01 << i_div_sel) - 8'h01);
	assign tick = (div_cnt_q & div_mask) == div_mask;
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			div_cnt_q <= 7'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 7'h01;
		end
	end
	// ****************************************
	// Per-bit hold until a full bus clock period passed
	// ****************************************
	logic [WIDTH-1:0] seen_q;
	genvar k;
	for (k = 0; k < WIDTH; k++) begin : g_bit
		always_ff @(posedge i_clock or negedge i_nrst) begin
			if (!i_nrst) begin
				o_active[k] <= 1'b0;
				seen_q[k] <= 1'b0;
			end else if (!o_active[k]) begin
				o_active[k] <= i_set[k];
				seen_q[k] <= 1'b0;
			end else if (tick) begin
				seen_q[k] <= 1'b1;
				o_active[k] <= !seen_q[k];
			end
		end
	end
endmodule : prnr_rst_pulse

// ==== rtl/prnr_bank.sv ====
// Clock and reset control register bank with peripheral resets and NMI routing.
// Assumes an AXI4-Lite master with one write and one read outstanding, and flag inputs
// that are held by their owning blocks until software clears them there.
//
// What this block does
// - Reset bits set only by writing one; zero ignored; hardware clears them afterwards.
// - Group1 reset: bit7 serial2, bit4 two-wire1, bits3-0 timers 7-4; rest reserved.
// - Group2 reset: bit2 serial3, bit1 segment display, bit0 LED pulse unit.
// - Group1 and group2 reset registers read zero after chip reset.
// - Group clock enable and reset pairs decode at their absolute addresses.
// - Unit registers decode at their offsets from the control unit base.
// - Routing enables change only when the upper key field holds the unlock value.
// - Routing bit2 sends line0 rising and falling flags to the NMI until cleared.
// - Line0 NMI routing takes precedence over its ordinary interrupt.
// - Routing bit1 sends the comparator flag to the NMI until cleared.
// - Comparator NMI routing takes precedence over its ordinary interrupt.
// - Routing bit0 sends the clock-failure flag to the NMI; only reset clears it.
// - Clock-failure NMI routing takes precedence over the ordinary clock unit interrupt.
// - Clock-failure flag shows in the clock status register and wakes from stop.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
module prnr_bank (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [31:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic i_line0_rise_flag,
	input wire logic i_line0_fall_flag,
	input wire logic i_line0_irq_req,
	input wire logic i_comparator_event_flag,
	input wire logic i_comparator_irq_req,
	input wire logic i_clockfail_detect,
	input wire logic i_clock_unit_irq_enable,
	output logic o_nmi,
	output logic o_line0_irq,
	output logic o_comparator_irq,
	output logic o_clock_unit_irq,
	output logic o_stop_wakeup,
	output logic [1:0] o_core_periph_reset,
	output logic [8:0] o_grp0_periph_reset,
	output logic [7:0] o_grp1_periph_reset,
	output logic [2:0] o_grp2_periph_reset,
	output logic o_irq
);
	// ****************************************
	// Address decoding
	// ****************************************
	function automatic logic [4:0] reg_index(input logic [31:0] a);
		logic [31:0] ofs;
		ofs = a - prnr_pkg::UNIT_BASE;
		if (a == prnr_pkg::ADDR_G0_CE) reg_index = prnr_pkg::IDX_G0_CE;
		else if (a == prnr_pkg::ADDR_G0_RST) reg_index = prnr_pkg::IDX_G0_RST;
		else if (a == prnr_pkg::ADDR_G1_CE) reg_index = prnr_pkg::IDX_G1_CE;
		else if (a == prnr_pkg::ADDR_G1_RST) reg_index = prnr_pkg::IDX_G1_RST;
		else if (a == prnr_pkg::ADDR_G2_CE) reg_index = prnr_pkg::IDX_G2_CE;
		else if (a == prnr_pkg::ADDR_G2_RST) reg_index = prnr_pkg::IDX_G2_RST;
		else if (ofs == prnr_pkg::OFS_CORE_CE) reg_index = prnr_pkg::IDX_CORE_CE;
		else if (ofs == prnr_pkg::OFS_CORE_RST) reg_index = prnr_pkg::IDX_CORE_RST;
		else if (ofs == prnr_pkg::OFS_KEY) reg_index = prnr_pkg::IDX_KEY;
		else if (ofs == prnr_pkg::OFS_SYS_SEL) reg_index = prnr_pkg::IDX_SYS_SEL;
		else if (ofs == prnr_pkg::OFS_PER_SEL) reg_index = prnr_pkg::IDX_PER_SEL;
		else if (ofs == prnr_pkg::OFS_PLL) reg_index = prnr_pkg::IDX_PLL;
		else if (ofs == prnr_pkg::OFS_STATUS) reg_index = prnr_pkg::IDX_STATUS;
		else if (ofs == prnr_pkg::OFS_CALIB) reg_index = prnr_pkg::IDX_CALIB;
		else if (ofs == prnr_pkg::OFS_ROUTE) reg_index = prnr_pkg::IDX_ROUTE;
		else if (ofs == prnr_pkg::OFS_EVENT) reg_index = prnr_pkg::IDX_EVENT;
		else if (ofs == prnr_pkg::OFS_MASK) reg_index = prnr_pkg::IDX_MASK;
		else reg_index = prnr_pkg::IDX_NONE;
	endfunction : reg_index

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// ****************************************
	// Write channel
	// ****************************************
	logic aw_hold_q;
	logic w_hold_q;
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_hs;
	logic w_hs;
	logic wr_do;
	logic aw_hold_d;
	logic w_hold_d;
	logic [4:0] wr_idx;
	logic [31:0] wr_val;
	logic [31:0] wr_ones;
	assign aw_hs = i_awvalid && o_awready;
	assign w_hs = i_wvalid && o_wready;
	assign wr_do = aw_hold_q && w_hold_q && !o_bvalid;
	assign aw_hold_d = (aw_hold_q || aw_hs) && !wr_do;
	assign w_hold_d = (w_hold_q || w_hs) && !wr_do;
	assign wr_idx = reg_index(aw_addr_q);
	assign wr_ones = merge(prnr_pkg::RST_ZERO, w_data_q, w_strb_q);

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= prnr_pkg::RESP_OKAY;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			o_awready <= !aw_hold_d;
			o_wready <= !w_hold_d;
			if (wr_do) begin
				o_bvalid <= 1'b1;
				o_bresp <= (wr_idx == prnr_pkg::IDX_NONE) ? prnr_pkg::RESP_DECERR : prnr_pkg::RESP_OKAY;
			end else if (i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (aw_hs) begin
			aw_addr_q <= i_awaddr;
		end
		if (w_hs) begin
			w_data_q <= i_wdata;
			w_strb_q <= i_wstrb;
		end
	end

	// ****************************************
	// Plain storage registers
	// ****************************************
	logic [31:0] core_ce_q;
	logic [31:0] g0_ce_q;
	logic [31:0] g1_ce_q;
	logic [31:0] g2_ce_q;
	logic [31:0] misc_q [prnr_pkg::MISC_COUNT];
	logic wr_misc;
	logic [2:0] misc_sel;
	assign wr_misc = wr_do && (wr_idx >= prnr_pkg::IDX_KEY) && (wr_idx <= prnr_pkg::IDX_CALIB);
	assign misc_sel = 3'(wr_idx - prnr_pkg::IDX_KEY);

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			core_ce_q <= prnr_pkg::RST_CORE_CE;
			g0_ce_q <= prnr_pkg::RST_ZERO;
			g1_ce_q <= prnr_pkg::RST_ZERO;
			g2_ce_q <= prnr_pkg::RST_ZERO;
			for (int i = 0; i < prnr_pkg::MISC_COUNT; i++) begin
				misc_q[i] <= prnr_pkg::RST_ZERO;
			end
		end else if (wr_do) begin
			if (wr_idx == prnr_pkg::IDX_CORE_CE) core_ce_q <= merge(core_ce_q, w_data_q, w_strb_q) & prnr_pkg::MASK_CORE_CE;
			if (wr_idx == prnr_pkg::IDX_G0_CE) g0_ce_q <= merge(g0_ce_q, w_data_q, w_strb_q) & prnr_pkg::MASK_G0_CE;
			if (wr_idx == prnr_pkg::IDX_G1_CE) g1_ce_q <= merge(g1_ce_q, w_data_q, w_strb_q) & prnr_pkg::MASK_G1_CE;
			if (wr_idx == prnr_pkg::IDX_G2_CE) g2_ce_q <= merge(g2_ce_q, w_data_q, w_strb_q) & prnr_pkg::MASK_G2_CE;
			if (wr_misc) misc_q[misc_sel] <= merge(misc_q[misc_sel], w_data_q, w_strb_q);
		end
	end

	// ****************************************
	// Self-clearing peripheral resets
	// ****************************************
	logic [31:0] set_core;
	logic [31:0] set_g0;
	logic [31:0] set_g1;
	logic [31:0] set_g2;
	assign set_core = (wr_do && wr_idx == prnr_pkg::IDX_CORE_RST) ? (wr_ones & prnr_pkg::MASK_CORE_RST) : 32'h0000_0000;
	assign set_g0 = (wr_do && wr_idx == prnr_pkg::IDX_G0_RST) ? (wr_ones & prnr_pkg::MASK_G0_RST) : 32'h0000_0000;
	assign set_g1 = (wr_do && wr_idx == prnr_pkg::IDX_G1_RST) ? (wr_ones & prnr_pkg::MASK_G1_RST) : 32'h0000_0000;
	assign set_g2 = (wr_do && wr_idx == prnr_pkg::IDX_G2_RST) ? (wr_ones & prnr_pkg::MASK_G2_RST) : 32'h0000_0000;

	prnr_rst_pulse #(.WIDTH(2)) u_core_rst (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_set(set_core[1:0]),
		.i_div_sel(core_ce_q[prnr_pkg::CLKDIV_LSB +: 3]),
		.o_active(o_core_periph_reset)
	);
	prnr_rst_pulse #(.WIDTH(9)) u_g0_rst (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_set(set_g0[8:0]),
		.i_div_sel(g0_ce_q[prnr_pkg::CLKDIV_LSB +: 3]),
		.o_active(o_grp0_periph_reset)
	);
	prnr_rst_pulse #(.WIDTH(8)) u_g1_rst (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_set(set_g1[7:0]),
		.i_div_sel(g1_ce_q[prnr_pkg::CLKDIV_LSB +: 3]),
		.o_active(o_grp1_periph_reset)
	);
	prnr_rst_pulse #(.WIDTH(3)) u_g2_rst (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_set(set_g2[2:0]),
		.i_div_sel(g2_ce_q[prnr_pkg::CLKDIV_LSB +: 3]),
		.o_active(o_grp2_periph_reset)
	);

	// ****************************************
	// NMI routing and clock failure
	// ****************************************
	logic [2:0] route_q;
	logic clkfail_q;
	logic wr_route;
	logic key_ok;
	logic nmi_d;
	assign wr_route = wr_do && wr_idx == prnr_pkg::IDX_ROUTE;
	assign key_ok = (&w_strb_q[3:2]) && w_data_q[prnr_pkg::KEY_LSB +: 16] == prnr_pkg::KEY_VALUE;
	assign wr_val = merge(prnr_pkg::RST_ZERO, w_data_q, w_strb_q);
	assign nmi_d = (route_q[prnr_pkg::ROUTE_LINE0_BIT] && (i_line0_rise_flag || i_line0_fall_flag))
		|| (route_q[prnr_pkg::ROUTE_CMP_BIT] && i_comparator_event_flag)
		|| (route_q[prnr_pkg::ROUTE_CLKF_BIT] && clkfail_q);

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			route_q <= 3'h0;
			clkfail_q <= 1'b0;
			o_nmi <= 1'b0;
			o_line0_irq <= 1'b0;
			o_comparator_irq <= 1'b0;
			o_clock_unit_irq <= 1'b0;
			o_stop_wakeup <= 1'b0;
		end else begin
			if (wr_route && key_ok && w_strb_q[0]) begin
				route_q <= wr_val[2:0];
			end
			clkfail_q <= clkfail_q || i_clockfail_detect;
			o_nmi <= nmi_d;
			o_line0_irq <= i_line0_irq_req && !route_q[prnr_pkg::ROUTE_LINE0_BIT];
			o_comparator_irq <= i_comparator_irq_req && !route_q[prnr_pkg::ROUTE_CMP_BIT];
			o_clock_unit_irq <= clkfail_q && i_clock_unit_irq_enable && !route_q[prnr_pkg::ROUTE_CLKF_BIT];
			o_stop_wakeup <= clkfail_q;
		end
	end

	// ****************************************
	// Event status, mask and interrupt
	// ****************************************
	logic [2:0] evt_q;
	logic [2:0] mask_q;
	logic [2:0] evt_set;
	logic [2:0] evt_clr;
	assign evt_set[prnr_pkg::EV_CLKFAIL_BIT] = i_clockfail_detect && !clkfail_q;
	assign evt_set[prnr_pkg::EV_NMI_BIT] = nmi_d && !o_nmi;
	assign evt_set[prnr_pkg::EV_KEYREJ_BIT] = wr_route && !key_ok;
	assign evt_clr = (wr_do && wr_idx == prnr_pkg::IDX_EVENT) ? wr_ones[2:0] : 3'h0;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			evt_q <= 3'h0;
			mask_q <= 3'h0;
			o_irq <= 1'b0;
		end else begin
			evt_q <= (evt_q & ~evt_clr) | evt_set;
			if (wr_do && wr_idx == prnr_pkg::IDX_MASK) begin
				mask_q <= wr_ones[2:0];
			end
			o_irq <= |(evt_q & mask_q);
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	logic ar_hs;
	logic rvalid_d;
	logic [4:0] rd_idx;
	logic [31:0] rd_val;
	assign ar_hs = i_arvalid && o_arready;
	assign rvalid_d = ar_hs || (o_rvalid && !i_rready);
	assign rd_idx = reg_index(i_araddr);

	always_comb begin
		rd_val = 32'h0000_0000;
		case (rd_idx)
			prnr_pkg::IDX_CORE_CE: rd_val = core_ce_q;
			prnr_pkg::IDX_CORE_RST: rd_val = {30'h0, o_core_periph_reset};
			prnr_pkg::IDX_KEY: rd_val = misc_q[0];
			prnr_pkg::IDX_SYS_SEL: rd_val = misc_q[1];
			prnr_pkg::IDX_PER_SEL: rd_val = misc_q[2];
			prnr_pkg::IDX_PLL: rd_val = misc_q[3];
			prnr_pkg::IDX_CALIB: rd_val = misc_q[4];
			prnr_pkg::IDX_STATUS: rd_val[prnr_pkg::STS_CLKFAIL_BIT] = clkfail_q;
			prnr_pkg::IDX_ROUTE: rd_val = {29'h0, route_q};
			prnr_pkg::IDX_G0_CE: rd_val = g0_ce_q;
			prnr_pkg::IDX_G0_RST: rd_val = {23'h0, o_grp0_periph_reset};
			prnr_pkg::IDX_G1_CE: rd_val = g1_ce_q;
			prnr_pkg::IDX_G1_RST: rd_val = {24'h0, o_grp1_periph_reset};
			prnr_pkg::IDX_G2_CE: rd_val = g2_ce_q;
			prnr_pkg::IDX_G2_RST: rd_val = {29'h0, o_grp2_periph_reset};
			prnr_pkg::IDX_EVENT: rd_val = {29'h0, evt_q};
			prnr_pkg::IDX_MASK: rd_val = {29'h0, mask_q};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= prnr_pkg::RESP_OKAY;
		end else begin
			o_rvalid <= rvalid_d;
			o_arready <= !rvalid_d;
			if (ar_hs) begin
				o_rdata <= rd_val;
				o_rresp <= (rd_idx == prnr_pkg::IDX_NONE) ? prnr_pkg::RESP_DECERR : prnr_pkg::RESP_OKAY;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	a_zero_no_set: assert property (
		wr_do && wr_idx == prnr_pkg::IDX_G1_RST && !wr_ones[0] && !o_grp1_periph_reset[0]
		|=> !o_grp1_periph_reset[0]) else $error("reset bit set by a zero write");
	a_selfclear_bound: assert property (
		$rose(o_grp1_periph_reset[0]) |-> ##[2:300] !o_grp1_periph_reset[0]) else $error("reset bit never cleared");
	a_reserved_zero: assert property (
		o_grp1_periph_reset[6:5] == 2'h0) else $error("reserved reset bit set");
	a_grp2_set: assert property (
		wr_do && wr_idx == prnr_pkg::IDX_G2_RST && wr_ones[2] |=> o_grp2_periph_reset[2])
		else $error("serial3 reset not set");
	a_hold_period: assert property (
		$rose(o_grp2_periph_reset[1]) |-> o_grp2_periph_reset[1] [*2]) else $error("reset held too briefly");
	a_unmapped_err: assert property (
		wr_do && wr_idx == prnr_pkg::IDX_NONE |=> o_bvalid && o_bresp == prnr_pkg::RESP_DECERR)
		else $error("unmapped write not refused");
	a_key_guard: assert property (
		wr_route && !key_ok |=> route_q == $past(route_q)) else $error("routing changed without key");
	a_key_reads_zero: assert property (
		ar_hs && rd_idx == prnr_pkg::IDX_ROUTE |=> o_rdata[31:16] == 16'h0000) else $error("key field read nonzero");
	a_line0_nmi: assert property (
		route_q[prnr_pkg::ROUTE_LINE0_BIT] && i_line0_fall_flag |=> o_nmi) else $error("line0 nmi missing");
	a_line0_pref: assert property (
		route_q[prnr_pkg::ROUTE_LINE0_BIT] |=> !o_line0_irq) else $error("line0 ordinary irq not suppressed");
	a_cmp_nmi: assert property (
		route_q[prnr_pkg::ROUTE_CMP_BIT] && i_comparator_event_flag |=> o_nmi) else $error("comparator nmi missing");
	a_cmp_pref: assert property (
		route_q[prnr_pkg::ROUTE_CMP_BIT] |=> !o_comparator_irq) else $error("comparator irq not suppressed");
	a_clkf_sticky: assert property (
		clkfail_q |=> clkfail_q ##1 o_stop_wakeup) else $error("clock failure flag lost");
	a_clkf_pref: assert property (
		route_q[prnr_pkg::ROUTE_CLKF_BIT] |=> !o_clock_unit_irq) else $error("clock irq not suppressed");

	c_grp1_reset: cover property ($rose(o_grp1_periph_reset[7]));
	c_nmi_raise: cover property ($rose(o_nmi));
	c_key_reject: cover property (evt_set[prnr_pkg::EV_KEYREJ_BIT]);
endmodule : prnr_bank

// ==== bench/tb.sv ====
// Self-checking bench for the peripheral reset and NMI routing bank.
// Assumes prnr_pkg and prnr_bank are compiled first; one 20 MHz clock.
`timescale 1ns/10ps
module tb;
	// ****************
	// Signals
	// ****************
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, fall_f = 1'b0;
	logic [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0, rdv, lf = 32'h6CDC, r_dat;
	logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, nmi, l0_irq, cmp_irq, cu_irq, wake, irq;
	logic [1:0] b_rsp, r_rsp, rsp, core_rst;
	logic [2:0] flag_v = 3'h0, req_v = 3'h0, g2_rst;
	logic [8:0] g0_rst;
	logic [7:0] g1_rst;
	logic [7:0] ofs [5] = '{8'h0C, 8'h14, 8'h18, 8'h1C, 8'h28};
	int bad_count = 0;
	int n_checks = 0;
	always #25 i_clock = ~i_clock;
	prnr_bank DUT (.i_clock(i_clock), .i_nrst(i_nrst), .i_awvalid(aw_v), .o_awready(aw_rdy), .i_awaddr(aw_a),
		.i_wvalid(w_v), .o_wready(w_rdy), .i_wdata(w_d), .i_wstrb(4'hF), .o_bvalid(b_vld), .i_bready(b_r),
		.o_bresp(b_rsp), .i_arvalid(ar_v), .o_arready(ar_rdy), .i_araddr(ar_a), .o_rvalid(r_vld),
		.i_rready(r_r), .o_rdata(r_dat), .o_rresp(r_rsp), .i_line0_rise_flag(flag_v[2]),
		.i_line0_fall_flag(fall_f), .i_line0_irq_req(req_v[2]), .i_comparator_event_flag(flag_v[1]),
		.i_comparator_irq_req(req_v[1]), .i_clockfail_detect(flag_v[0]), .i_clock_unit_irq_enable(req_v[0]),
		.o_nmi(nmi), .o_line0_irq(l0_irq), .o_comparator_irq(cmp_irq), .o_clock_unit_irq(cu_irq),
		.o_stop_wakeup(wake), .o_core_periph_reset(core_rst), .o_grp0_periph_reset(g0_rst),
		.o_grp1_periph_reset(g1_rst), .o_grp2_periph_reset(g2_rst), .o_irq(irq));
	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	function automatic logic [31:0] rst_exp(input int grp, input logic [31:0] d);
		return (grp == 1) ? (d & 32'h0000_009F) : (d & 32'h0000_0007);
	endfunction : rst_exp
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s seen %h want %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		aw_v <= 1'b1;
		aw_a <= a;
		w_v <= 1'b1;
		w_d <= d;
		while (!(ad && wd)) begin
			@(posedge i_clock);
			if (!ad && aw_rdy) begin
				ad = 1'b1;
				aw_v <= 1'b0;
			end
			if (!wd && w_rdy) begin
				wd = 1'b1;
				w_v <= 1'b0;
			end
		end
		b_r <= 1'b1;
		do @(posedge i_clock); while (!b_vld);
		rsp = b_rsp;
		b_r <= 1'b0;
	endtask : wr
	task automatic rc(input logic [31:0] a, input logic [31:0] exp, input string msg);
		ar_v <= 1'b1;
		ar_a <= a;
		do @(posedge i_clock); while (!ar_rdy);
		ar_v <= 1'b0;
		r_r <= 1'b1;
		do @(posedge i_clock); while (!r_vld);
		rdv = r_dat;
		rsp = r_rsp;
		r_r <= 1'b0;
		check(rdv, exp, msg);
	endtask : rc
	task automatic ck_nmi(input logic [2:0] exp, input string msg);
		repeat (2) @(posedge i_clock);
		check({29'h0, nmi, l0_irq, cmp_irq}, {29'h0, exp}, msg);
	endtask : ck_nmi
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	// ****************
	// Tests
	// ****************
	initial begin
		repeat (20000) @(posedge i_clock);
		bad_count++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge i_clock);
		i_nrst <= 1'b1;
		@(posedge i_clock);
		rc(32'h4002_1004, 32'h0, "g1 reset value");
		rc(32'h4002_2004, 32'h0, "g2 reset value");
		rc(32'h4000_3000, 32'h0020_0000, "core enable value");
		rc(32'h4002_3004, 32'h0, "unmapped read");
		check({30'h0, rsp}, 32'h3, "unmapped resp");
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			lf = (i == 0) ? 32'hFFFF_FFFF : nxt(lf);
			wr(32'h4002_1004, lf);
			check({24'h0, g1_rst}, rst_exp(1, lf), "g1 pulse");
			wr(32'h4002_2004, lf);
			check({29'h0, g2_rst}, rst_exp(2, lf), "g2 pulse");
			repeat (3) @(posedge i_clock);
			check({21'h0, g1_rst, g2_rst}, 32'h0, "self clear");
		end
		wr(32'h4000_3004, 32'hFFFF_FFFF);
		check({30'h0, core_rst}, 32'h3, "core pulse");
		wr(32'h4002_0004, 32'hFFFF_FFFF);
		check({23'h0, g0_rst}, 32'h1FF, "g0 pulse");
		repeat (12) @(posedge i_clock);
		check({23'h0, g0_rst}, 32'h0, "g0 clear");
		wr(32'h4002_1004, 32'h0);
		check({24'h0, g1_rst}, 32'h0, "write zero");
		rc(32'h4002_1004, 32'h0, "g1 after clear");
		wr(32'h4002_1000, 32'h0070_0000);
		rc(32'h4002_1000, 32'h0070_0000, "g1 enable");
		wr(32'h4002_1004, 32'h0000_0080);
		repeat (100) @(posedge i_clock);
		check({24'h0, g1_rst}, 32'h80, "slow hold");
		repeat (160) @(posedge i_clock);
		check({24'h0, g1_rst}, 32'h0, "slow clear");
		$display("test resets done");
		foreach (ofs[i]) begin
			lf = nxt(lf);
			wr(32'h4000_3000 + ofs[i], lf);
			rc(32'h4000_3000 + ofs[i], lf, "plain reg");
		end
		$display("test map done");
		wr(32'h4000_302C, 32'h0000_0007);
		rc(32'h4000_302C, 32'h0, "no key");
		rc(32'h4000_3030, 32'h4, "key reject event");
		check({31'h0, irq}, 32'h0, "masked irq");
		wr(32'h4000_3034, 32'h4);
		repeat (2) @(posedge i_clock);
		check({31'h0, irq}, 32'h1, "unmasked irq");
		wr(32'h4000_3030, 32'h4);
		repeat (2) @(posedge i_clock);
		check({31'h0, irq}, 32'h0, "cleared irq");
		wr(32'h4000_302C, 32'hA05F_0006);
		rc(32'h4000_302C, 32'h6, "keyed write");
		$display("test key done");
		wr(32'h4000_302C, 32'hA05F_0000);
		req_v <= 3'h6;
		flag_v <= 3'h6;
		ck_nmi(3'b011, "plain irqs");
		wr(32'h4000_302C, 32'hA05F_0004);
		ck_nmi(3'b101, "line0 nmi");
		wr(32'h4000_302C, 32'hA05F_0002);
		ck_nmi(3'b110, "cmp nmi");
		flag_v <= 3'h0;
		ck_nmi(3'b010, "cmp cleared");
		wr(32'h4000_302C, 32'hA05F_0004);
		fall_f <= 1'b1;
		ck_nmi(3'b101, "fall nmi");
		fall_f <= 1'b0;
		ck_nmi(3'b001, "line0 cleared");
		$display("test routing done");
		wr(32'h4000_302C, 32'hA05F_0001);
		req_v <= 3'h1;
		flag_v <= 3'h1;
		@(posedge i_clock);
		flag_v <= 3'h0;
		repeat (20) @(posedge i_clock);
		check({29'h0, nmi, cu_irq, wake}, 32'h5, "clock fail nmi");
		rc(32'h4000_3020, 32'h1, "status flag");
		wr(32'h4000_3034, 32'h1);
		repeat (2) @(posedge i_clock);
		check({31'h0, irq}, 32'h1, "fail irq");
		wr(32'h4000_3030, 32'h7);
		repeat (2) @(posedge i_clock);
		check({30'h0, irq, nmi}, 32'h1, "event cleared");
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_nrst <= 1'b1;
		@(posedge i_clock);
		rc(32'h4000_3020, 32'h0, "flag after reset");
		check({31'h0, nmi}, 32'h0, "nmi after reset");
		$display("test clock fail done");
		give_verdict();
	end
endmodule : tb
